// >>> scpi_consts.svh
// Constants for the serial command parser: clock, link, characters and keywords.
// Assumes a single 25 MHz system clock; included by the package and both modules.
`ifndef SCPI_CONSTS_SVH
`define SCPI_CONSTS_SVH

// ----------------------------------------
// Clock and serial link
// ----------------------------------------
`define CLK_HZ      25000000
`define BAUD_RATE   115200
`define MIN_DIV     4

// ----------------------------------------
// Token storage
// ----------------------------------------
`define TOK_CHARS   12
`define TOK_BITS    96
`define LEN_BITS    4

// ----------------------------------------
// Characters
// ----------------------------------------
`define CH_LF       8'h0A
`define CH_CR       8'h0D
`define CH_SPACE    8'h20
`define CH_COLON    8'h3A
`define CH_QUERY    8'h3F
`define CH_ZERO     8'h30
`define CH_ONE      8'h31
`define CH_NINE     8'h39
`define CH_UP_A     8'h41
`define CH_UP_Z     8'h5A
`define CH_LO_A     8'h61
`define CH_LO_Z     8'h7A
`define CASE_DIFF   8'h20

// ----------------------------------------
// Keywords, upper case, short and long forms
// ----------------------------------------
`define KW_OUTP_S   "OUTP"
`define KW_OUTP_L   "OUTPUT"
`define KW_STAT_S   "STAT"
`define KW_STAT_L   "STATE"
`define KW_INIT_S   "INIT"
`define KW_INIT_L   "INITIATE"
`define KW_IMM_S    "IMM"
`define KW_IMM_L    "IMMEDIATE"
`define KW_ON       "ON"
`define KW_OFF      "OFF"
`define KW_ONE      "1"
`define KW_ZERO     "0"

`endif

// >>> scpi_pkg.sv
// Types shared by the command parser and its serial link.
// Assumes scpi_consts.svh is on the include path.
`include "scpi_consts.svh"

package scpi_pkg;

	typedef enum logic [2:0] {
		PH_ROOT  = 3'b000,
		PH_NODE  = 3'b001,
		PH_PARAM = 3'b010,
		PH_END   = 3'b011,
		PH_ERR   = 3'b100
	} phase_e;

	typedef enum logic [1:0] {
		RT_NONE = 2'b00,
		RT_OUTP = 2'b01,
		RT_INIT = 2'b10
	} root_e;

	typedef enum logic [1:0] {
		PRM_NONE = 2'b00,
		PRM_ON   = 2'b01,
		PRM_OFF  = 2'b10
	} param_e;

	typedef enum logic [3:0] {
		TK_BAD  = 4'b0000,
		TK_OUTP = 4'b0001,
		TK_STAT = 4'b0010,
		TK_INIT = 4'b0011,
		TK_IMM  = 4'b0100,
		TK_ON   = 4'b0101,
		TK_OFF  = 4'b0110
	} tok_e;

endpackage : scpi_pkg

// >>> uart_link.sv
// Serial link, 8 data bits, no parity, 1 stop bit, no flow control.
// Assumes rxd is synchronous to mclk and rst_n is already synchronised.
`timescale 1ns/1ps
`include "scpi_consts.svh"

module uart_link
	import scpi_pkg::*;
#(
	parameter int CLK_HZ = `CLK_HZ,
	parameter int BAUD   = `BAUD_RATE
)(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       rxd,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic            txd
);

	localparam int DIV = (CLK_HZ + BAUD / 2) / BAUD;

	generate
		if (DIV < `MIN_DIV)
		begin : g_bad_div
			$error("uart_link: clock too slow for baud rate");
		end
	endgenerate

	typedef struct packed {
		logic        rx_busy;
		logic [15:0] rx_div;
		logic [3:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic [7:0]  rx_data;
		logic        rx_valid;
		logic        tx_busy;
		logic [15:0] tx_div;
		logic [3:0]  tx_bit;
		logic [8:0]  tx_sh;
		logic        txd;
	} link_s;

	link_s s_r;
	link_s s_nxt;

	assign rx_data  = s_r.rx_data;
	assign rx_valid = s_r.rx_valid;
	assign tx_ready = !s_r.tx_busy;
	assign txd      = s_r.txd;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rx_valid = 1'b0;
		// ----------------------------------------
		// Receiver: sample mid-bit, one enable per bit time
		// ----------------------------------------
		if (!s_r.rx_busy)
		begin
			if (!rxd)
			begin
				s_nxt.rx_busy = 1'b1;
				s_nxt.rx_div  = 16'(DIV / 2);
				s_nxt.rx_bit  = 4'h0;
			end
		end
		else if (s_r.rx_div != 16'h0000)
			s_nxt.rx_div = s_r.rx_div - 16'h0001;
		else
		begin
			s_nxt.rx_div = 16'(DIV - 1);
			s_nxt.rx_bit = s_r.rx_bit + 4'h1;
			if (s_r.rx_bit == 4'h0 && rxd)
				s_nxt.rx_busy = 1'b0;                     // Glitch, not a start bit
			else if (s_r.rx_bit == 4'h9)
			begin
				s_nxt.rx_busy  = 1'b0;
				s_nxt.rx_data  = s_r.rx_sh;
				s_nxt.rx_valid = rxd;                     // Framing error drops byte
			end
			else if (s_r.rx_bit != 4'h0)
				s_nxt.rx_sh = {rxd, s_r.rx_sh[7:1]};      // LSB first
		end
		// ----------------------------------------
		// Transmitter: start, 8 data, stop
		// ----------------------------------------
		if (!s_r.tx_busy)
		begin
			if (tx_valid)
			begin
				s_nxt.tx_busy = 1'b1;
				s_nxt.tx_sh   = {1'b1, tx_data};
				s_nxt.tx_div  = 16'(DIV - 1);
				s_nxt.tx_bit  = 4'h0;
				s_nxt.txd     = 1'b0;
			end
		end
		else if (s_r.tx_div != 16'h0000)
			s_nxt.tx_div = s_r.tx_div - 16'h0001;
		else
		begin
			s_nxt.tx_div = 16'(DIV - 1);
			if (s_r.tx_bit == 4'h9)
				s_nxt.tx_busy = 1'b0;                     // Stop bit served in full
			else
			begin
				s_nxt.txd    = s_r.tx_sh[0];
				s_nxt.tx_sh  = {1'b1, s_r.tx_sh[8:1]};
				s_nxt.tx_bit = s_r.tx_bit + 4'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r     <= '0;
			s_r.txd <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

endmodule : uart_link

// >>> scpi_serial_command_parser.sv
// Text command interpreter for the output subsystem, fed by a serial link
// and by a parallel byte port from the instrument bus front end.
// Assumes the host ends each message with a line feed and waits for replies.
`timescale 1ns/1ps
`include "scpi_consts.svh"

module scpi_serial_command_parser
	import scpi_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       uart_rxd,
	output logic            uart_txd,
	input  wire logic [7:0] par_data,
	input  wire logic       par_valid,
	output logic            par_ready,
	output logic      [7:0] par_reply_data,
	output logic            par_reply_valid,
	input  wire logic       par_reply_ready,
	output logic            rf_signal_output,
	output logic            init_pulse
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n_s;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n_s = rst_sync_r[1];

	// ----------------------------------------
	// Serial link
	// ----------------------------------------
	logic [7:0] rx_data;
	logic [7:0] reply_tx;
	logic       rx_valid;
	logic       tx_valid;
	logic       tx_ready;

	uart_link #(
		.CLK_HZ (`CLK_HZ),
		.BAUD   (`BAUD_RATE)
	) u_link (
		.mclk     (mclk),
		.rst_n    (rst_n_s),
		.rxd      (uart_rxd),
		.rx_data  (rx_data),
		.rx_valid (rx_valid),
		.tx_data  (reply_tx),
		.tx_valid (tx_valid),
		.tx_ready (tx_ready),
		.txd      (uart_txd)
	);

	// ----------------------------------------
	// Parser state
	// ----------------------------------------
	typedef struct packed {
		logic [`TOK_BITS-1:0] tok;
		logic [`LEN_BITS-1:0] len;
		phase_e               ph;
		root_e                root;
		logic                 query;
		param_e               prm;
		logic                 rf_on;
		logic                 init_pulse;
		logic [1:0]           reply_cnt;
		logic                 reply_src;
		logic [7:0]           reply_byte;
	} parse_s;

	parse_s s_r;
	parse_s s_nxt;

	// Exact match against either form only, so partial spellings fall to TK_BAD
	function automatic tok_e classify(input logic [`TOK_BITS-1:0] t);
		tok_e k;
		k = TK_BAD;
		if (t == `TOK_BITS'(`KW_OUTP_S) || t == `TOK_BITS'(`KW_OUTP_L))
			k = TK_OUTP;
		else if (t == `TOK_BITS'(`KW_STAT_S) || t == `TOK_BITS'(`KW_STAT_L))
			k = TK_STAT;
		else if (t == `TOK_BITS'(`KW_INIT_S) || t == `TOK_BITS'(`KW_INIT_L))
			k = TK_INIT;
		else if (t == `TOK_BITS'(`KW_IMM_S) || t == `TOK_BITS'(`KW_IMM_L))
			k = TK_IMM;
		else if (t == `TOK_BITS'(`KW_ON) || t == `TOK_BITS'(`KW_ONE))
			k = TK_ON;
		else if (t == `TOK_BITS'(`KW_OFF) || t == `TOK_BITS'(`KW_ZERO))
			k = TK_OFF;
		return k;
	endfunction : classify

	// Consume the collected token according to where in the message it stands
	function automatic parse_s close_tok(input parse_s st);
		parse_s r;
		tok_e   k;
		r = st;
		k = classify(st.tok);
		if (st.len != '0)
		begin
			case (st.ph)
				PH_ROOT:
					if (k == TK_OUTP)
						r.root = RT_OUTP;
					else if (k == TK_INIT)
						r.root = RT_INIT;
					else
						r.ph = PH_ERR;
				PH_NODE:
					// Explicit default node changes nothing, same as omitting it
					if (!((st.root == RT_OUTP && k == TK_STAT) ||
						(st.root == RT_INIT && k == TK_IMM)))
						r.ph = PH_ERR;
				PH_PARAM:
					if (st.prm != PRM_NONE || st.root != RT_OUTP)
						r.ph = PH_ERR;
					else if (k == TK_ON)
						r.prm = PRM_ON;
					else if (k == TK_OFF)
						r.prm = PRM_OFF;
					else
						r.ph = PH_ERR;
				default:
					r.ph = PH_ERR;
			endcase
		end
		r.tok = '0;
		r.len = '0;
		return r;
	endfunction : close_tok

	// Act on a finished message; anything not matched is dropped silently
	function automatic parse_s execute(input parse_s st, input logic src);
		parse_s r;
		r = st;
		if (st.ph != PH_ERR)
		begin
			case (st.root)
				RT_OUTP:
					if (st.query && st.prm == PRM_NONE)
					begin
						r.reply_cnt  = 2'd2;
						r.reply_src  = src;
						r.reply_byte = st.rf_on ? `CH_ONE : `CH_ZERO;
					end
					else if (!st.query && st.prm != PRM_NONE)
						r.rf_on = (st.prm == PRM_ON);
				RT_INIT:
					if (!st.query && st.prm == PRM_NONE)
						r.init_pulse = 1'b1;                              // Query falls through
				default:
					r.rf_on = st.rf_on;
			endcase
		end
		r.tok   = '0;
		r.len   = '0;
		r.ph    = PH_ROOT;
		r.root  = RT_NONE;
		r.query = 1'b0;
		r.prm   = PRM_NONE;
		return r;
	endfunction : execute

	// ----------------------------------------
	// Byte intake and reply drain
	// ----------------------------------------
	logic sink_ready;

	// A reply in flight stalls the parallel port; the serial port cannot stall
	assign par_ready       = (s_r.reply_cnt == 2'd0) && !rx_valid;
	assign tx_valid        = (s_r.reply_cnt != 2'd0) && !s_r.reply_src;
	assign par_reply_valid = (s_r.reply_cnt != 2'd0) && s_r.reply_src;
	assign par_reply_data  = s_r.reply_byte;
	assign reply_tx        = s_r.reply_byte;
	assign sink_ready      = s_r.reply_src ? par_reply_ready : tx_ready;
	assign rf_signal_output = s_r.rf_on;
	assign init_pulse      = s_r.init_pulse;

	logic [7:0] c;
	logic       take;
	logic       from_par;
	logic       is_alnum;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.init_pulse = 1'b0;
		c        = 8'h00;
		take     = 1'b0;
		from_par = 1'b0;
		// Both ports feed the same interpreter
		if (rx_valid)
		begin
			c    = rx_data;
			take = 1'b1;
		end
		else if (par_valid && par_ready)
		begin
			c        = par_data;
			take     = 1'b1;
			from_par = 1'b1;
		end
		if (c >= `CH_LO_A && c <= `CH_LO_Z)
			c = c - `CASE_DIFF;
		is_alnum = (c >= `CH_UP_A && c <= `CH_UP_Z) || (c >= `CH_ZERO && c <= `CH_NINE);

		if (s_r.reply_cnt != 2'd0 && sink_ready)
		begin
			s_nxt.reply_cnt  = s_r.reply_cnt - 2'd1;
			s_nxt.reply_byte = `CH_LF;
		end

		if (take)
		begin
			if (c == `CH_LF)
				s_nxt = execute(close_tok(s_nxt), from_par);
			else if (s_r.ph == PH_ERR || c == `CH_CR)
				s_nxt.ph = s_r.ph;
			else if (c == `CH_COLON)
			begin
				s_nxt = close_tok(s_nxt);
				if (s_nxt.ph == PH_ROOT && s_nxt.root != RT_NONE)
					s_nxt.ph = PH_NODE;
				else if (s_nxt.ph != PH_ROOT)
					s_nxt.ph = PH_ERR;
			end
			else if (c == `CH_QUERY || c == `CH_SPACE)
			begin
				s_nxt = close_tok(s_nxt);
				if (s_nxt.ph == PH_PARAM && c == `CH_SPACE)
					s_nxt.ph = PH_PARAM;
				else if ((s_nxt.ph == PH_ROOT || s_nxt.ph == PH_NODE) &&
					s_nxt.root != RT_NONE)
				begin
					// Header may stop at the root, node left out
					s_nxt.query = (c == `CH_QUERY);
					s_nxt.ph    = (c == `CH_QUERY) ? PH_END : PH_PARAM;
				end
				else if (!(s_nxt.ph == PH_ROOT && c == `CH_SPACE))
					s_nxt.ph = PH_ERR;
			end
			else if (is_alnum && s_r.ph != PH_END)
			begin
				// Overlong tokens can never match, so they poison the message
				if (s_r.len == `LEN_BITS'(`TOK_CHARS))
					s_nxt.ph = PH_ERR;
				else
				begin
					s_nxt.tok = {s_r.tok[`TOK_BITS-9:0], c};
					s_nxt.len = s_r.len + `LEN_BITS'(1);
				end
			end
			else
				s_nxt.ph = PH_ERR;                                    // Brackets land here
		end
	end

	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule : scpi_serial_command_parser

// >>> scpi_parser_properties.sv
// Checker: port-level properties of the serial command parser.
// Assumes it is bound onto the parser top and sees only its ports.
`timescale 1ns/1ps

module scpi_parser_properties
(
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       uart_rxd,
	input wire logic       uart_txd,
	input wire logic [7:0] par_data,
	input wire logic       par_valid,
	input wire logic       par_ready,
	input wire logic [7:0] par_reply_data,
	input wire logic       par_reply_valid,
	input wire logic       par_reply_ready,
	input wire logic       rf_signal_output,
	input wire logic       init_pulse
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Serial traffic is invisible here, so an idle line stands in for its terminator
	sequence lf_done_s;
		$past(par_valid && par_ready && par_data == 8'h0A) || uart_rxd;
	endsequence

	sequence reply_lf_s;
		par_reply_valid && par_reply_data == 8'h0A;
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	init_one_a: assert property (init_pulse |=> !init_pulse)
		else $error("init pulse longer than one cycle");
	reply_hold_a: assert property (par_reply_valid && !par_reply_ready
		|=> par_reply_valid && $stable(par_reply_data)) else $error("reply dropped");
	reply_digit_a: assert property ($rose(par_reply_valid)
		|-> par_reply_data == {7'h18, rf_signal_output}) else $error("wrong reply digit");
	reply_term_a: assert property (par_reply_valid && par_reply_ready
		&& par_reply_data != 8'h0A |=> reply_lf_s) else $error("no line feed after digit");
	ready_block_a: assert property (par_reply_valid |-> !par_ready)
		else $error("port ready during reply");
	rf_cause_a: assert property ($changed(rf_signal_output) |-> lf_done_s)
		else $error("output changed without terminator");
	init_cause_a: assert property (init_pulse |-> lf_done_s)
		else $error("init pulse without terminator");
	tx_start_a: assert property ($fell(uart_txd) |=> !uart_txd [*8])
		else $error("serial bit too short");
endmodule : scpi_parser_properties

bind scpi_serial_command_parser scpi_parser_properties chk (.mclk(mclk), .rstn(rstn),
	.uart_rxd(uart_rxd), .uart_txd(uart_txd), .par_data(par_data), .par_valid(par_valid),
	.par_ready(par_ready), .par_reply_data(par_reply_data), .par_reply_valid(par_reply_valid),
	.par_reply_ready(par_reply_ready), .rf_signal_output(rf_signal_output),
	.init_pulse(init_pulse));

// >>> scpi_host_model.sv
// Remote host: sends text over the serial link and collects replies.
// Assumes the parser divides 25 MHz by 217 for each bit.
`timescale 1ns/1ps

module scpi_host_model
(
	input  wire logic mclk,
	output logic      rxd,
	input  wire logic txd
);
	localparam int BIT_CLKS = 217;
	logic [7:0] rx_q [$];
	logic [7:0] sh;

	initial rxd = 1'h1;

	// ----------------------------------------
	// Transmit, 8N1, LSB first, no flow control
	// ----------------------------------------
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			rxd = fr[i];
			repeat (BIT_CLKS) @(negedge mclk);
		end
	endtask : send_byte

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++)
			send_byte(s[i]);
	endtask : send_str

	// ----------------------------------------
	// Receive, sampled mid-bit
	// ----------------------------------------
	always
	begin
		@(negedge txd);
		repeat (BIT_CLKS / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge mclk);
			sh[i] = txd;
		end
		repeat (BIT_CLKS) @(posedge mclk);
		if (txd)
			rx_q.push_back(sh);
	end
endmodule : scpi_host_model

// >>> test_scpi_serial_command_parser.sv
// Testbench: commands over both remote ports, judged at the ports.
// Assumes the parser, its serial link and the host model are compiled first.
`timescale 1ns/1ps

module test_scpi_serial_command_parser;
	logic       mclk            = 1'h0;
	logic       rstn            = 1'h0;
	logic [7:0] par_data        = 8'h00;
	logic       par_valid       = 1'h0;
	logic       par_reply_ready = 1'h0;
	logic       uart_rxd;
	logic       uart_txd;
	logic       par_ready;
	logic [7:0] par_reply_data;
	logic       par_reply_valid;
	logic       rf_signal_output;
	logic       init_pulse;
	int         n_mismatch      = 0;
	int         comparisons     = 0;
	int         n_init          = 0;

	always #20 mclk = ~mclk;
	always @(posedge mclk) if (init_pulse === 1'h1) n_init++;

	scpi_serial_command_parser uut (.mclk(mclk), .rstn(rstn), .uart_rxd(uart_rxd),
		.uart_txd(uart_txd), .par_data(par_data), .par_valid(par_valid),
		.par_ready(par_ready), .par_reply_data(par_reply_data),
		.par_reply_valid(par_reply_valid), .par_reply_ready(par_reply_ready),
		.rf_signal_output(rf_signal_output), .init_pulse(init_pulse));
	scpi_host_model host (.mclk(mclk), .rxd(uart_rxd), .txd(uart_txd));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Data is left on the last byte, a line feed, after the message
	task automatic par_send(input string s);
		int w;
		for (int i = 0; i < s.len(); i++)
		begin
			@(negedge mclk);
			par_valid = 1'h1;
			par_data = s[i];
			w = 0;
			@(posedge mclk);
			while (par_ready !== 1'h1 && w < 50)
			begin
				w++;
				@(posedge mclk);
			end
		end
		@(negedge mclk);
		par_valid = 1'h0;
		repeat (3) @(negedge mclk);
	endtask : par_send

	task automatic rf_cmd(input string s, input logic e);
		par_send(s);
		check({7'h00, rf_signal_output}, {7'h00, e});
	endtask : rf_cmd

	task automatic par_reply(input logic [7:0] d);
		int w = 0;
		while (par_reply_valid !== 1'h1 && w < 50)
		begin
			w++;
			@(negedge mclk);
		end
		check(par_reply_data, d);
		@(negedge mclk);
		check(par_reply_data, d);
		par_reply_ready = 1'h1;
		@(negedge mclk);
		check(par_reply_data, 8'h0A);
		@(negedge mclk);
		par_reply_ready = 1'h0;
		check({7'h00, par_reply_valid}, 8'h00);
		check({7'h00, par_ready}, 8'h01);
	endtask : par_reply

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_set_forms;
		rf_cmd("OUTP ON\n", 1'h1);
		rf_cmd("output:state 0\n", 1'h0);
		rf_cmd("Outp 1\n", 1'h1);
		rf_cmd("OUTPUT:STAT OFF\n", 1'h0);
	endtask : t_set_forms

	task automatic t_query;
		par_send("OUTP?\n");
		check({7'h00, par_ready}, 8'h00);
		par_reply(8'h30);
		rf_cmd("outp:stat on\n", 1'h1);
		par_send("OUTPUT:STATE?\n");
		par_reply(8'h31);
	endtask : t_query

	task automatic t_bad;
		rf_cmd("OUTPU OFF\n", 1'h1);
		rf_cmd("OUTP:STA 0\n", 1'h1);
		rf_cmd("OUTP MAYBE\n", 1'h1);
	endtask : t_bad

	task automatic t_event;
		int k;
		k = n_init;
		par_send("INIT\n");
		check(8'(n_init - k), 8'h01);
		par_send("initiate:IMMEDIATE\n");
		check(8'(n_init - k), 8'h02);
		par_send("INIT?\n");
		repeat (20) @(negedge mclk);
		check(8'(n_init - k), 8'h02);
		check({7'h00, par_reply_valid}, 8'h00);
	endtask : t_event

	task automatic t_serial;
		int w = 0;
		host.send_str("outp:stat 0\n");
		repeat (5) @(negedge mclk);
		check({7'h00, rf_signal_output}, 8'h00);
		host.send_str("OUTP?\n");
		while (host.rx_q.size() < 2 && w < 6000)
		begin
			w++;
			@(negedge mclk);
		end
		check(host.rx_q[0], 8'h30);
		check(host.rx_q[1], 8'h0A);
	endtask : t_serial

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// Serial traffic dominates; about 43k cycles expected
	initial
	begin
		#4000000;
		n_mismatch++;
		tally_and_finish();
	end

	initial
	begin
		repeat (10) @(negedge mclk);
		rstn = 1'h1;
		repeat (4) @(negedge mclk);
		t_set_forms();
		t_query();
		t_bad();
		t_event();
		t_serial();
		tally_and_finish();
	end
endmodule : test_scpi_serial_command_parser
